/* File: mcs_pkg.sv */
// shared constants and carriers for the measuring circuit supervision block
package mcs_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the ahb-lite slave
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TCS_DLY = 8'h04;
  localparam logic [7:0] OFF_LOP_DLY = 8'h08;
  localparam logic [7:0] OFF_CTS_LIM = 8'h0c;
  localparam logic [7:0] OFF_CT_RATING = 8'h10;
  localparam logic [7:0] OFF_LOP_VTHR = 8'h14;
  localparam logic [7:0] OFF_LOP_ITHR = 8'h18;
  localparam logic [7:0] OFF_SUBSCR = 8'h1c;
  localparam logic [7:0] OFF_OC_ASSIGN = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [23:0] rsvd;
    logic winding_sel;     // side whose quantities feed the potential watch
    logic fuse_assigned;   // fuse-fail digital input is in use
    logic lop_use_breaker; // qualify potential loss with breaker closed when a switchgear is assigned
    logic block_allow;     // potential_loss_block_allow
    logic lop_enable;
    logic cts_enable;
    logic two_contact;     // both aux contacts looped into the trip circuit
    logic sg_assigned;     // a breaker switchgear is assigned
  } mcs_ctrl_t;

  typedef struct packed {
    logic [11:0] phase_prim;
    logic [3:0] phase_sec;
    logic [11:0] earth_prim;
    logic [3:0] earth_sec;
  } mcs_rating_t;
  localparam logic [31:0] CT_RATING_RST = 32'h0011_0011;

  typedef struct packed {
    logic [15:0] slope;  // slope_correction_factor, 8 fraction bits
    logic [15:0] offset; // fixed_offset_threshold
  } mcs_lim_t;
  localparam int SLOPE_FRAC = 8;

  typedef struct packed {
    logic [15:0] v_low;  // phase voltage loss level
    logic [15:0] v0_low; // residual voltage level
  } mcs_vthr_t;

  typedef struct packed {
    logic [15:0] i_low;   // load current level
    logic [15:0] i_rated; // rated current
  } mcs_ithr_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic block;
    logic fuse_fail;
    logic lop_alarm;
    logic lop_cond;
    logic cts_alarm;
    logic tcs_alarm;
    logic tcs_fault;
  } mcs_status_t;

  // measured quantities of one winding side, phasors signed
  typedef struct packed {
    logic [2:0][15:0] i_re;
    logic [2:0][15:0] i_im;
    logic [2:0][15:0] i_mag;
    logic [2:0][15:0] v_mag;
    logic [15:0] ig_re;
    logic [15:0] ig_im;
    logic [15:0] i0;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] v2;
  } mcs_meas_t;

  // ---------------------------------------------------------------
  // ratios and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  localparam logic [31:0] NEG_SEQ_PCT = 32'h0000_0028;
  localparam logic [31:0] RES_DIV = 32'h0000_000a;
  localparam int SYNC_CLOSED = 0;
  localparam int SYNC_OPEN = 1;
  localparam int SYNC_FUSE = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DELAY_UNIT_NS = 1000000;
  localparam int TICK_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;

endpackage

/* File: mcs_delay.sv */
// persistence timer: fires once its condition has held for a set time
`timescale 1ns/1ps
module mcs_delay #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] delay,
  output logic fired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic fired;
  } mcs_dly_state_t;

  mcs_dly_state_t st_reg;
  mcs_dly_state_t st_next;

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  // any drop of the condition restarts the wait from zero
  always_comb
  begin
    st_next = st_reg;
    if (!cond)
    begin
      st_next.cnt = '0;
      st_next.fired = 1'b0;
    end
    else if (st_reg.cnt >= delay)
      st_next.fired = 1'b1;
    else if (tick)
      st_next.cnt = st_reg.cnt + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign fired = st_reg.fired;

endmodule // mcs_delay

/* File: mcs_supervision.sv */
// measuring circuit supervision: trip circuit, ct and potential loss watches
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module mcs_supervision #(
  parameter int N_EL = 8,
  parameter int N_OC = 8,
  parameter int TICK_CYCLES = mcs_pkg::TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic breaker_closed_aux_contact,
  input wire logic breaker_open_aux_contact,
  input wire logic vt_fuse_fail_input,
  input wire logic breaker_closed,
  input wire mcs_pkg::mcs_meas_t [1:0] meas,
  input wire logic [N_OC-1:0] oc_pickup,
  output logic trip_circuit_alarm,
  output logic cts_alarm,
  output logic potential_loss_block_alarm,
  output logic fuse_fail,
  output logic [N_EL-1:0] elem_block
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [15:0] tick_cnt;
    logic tick;
    mcs_pkg::mcs_ctrl_t ctrl;
    logic [15:0] tcs_dly;
    logic [15:0] lop_dly;
    mcs_pkg::mcs_lim_t lim;
    mcs_pkg::mcs_rating_t rating;
    mcs_pkg::mcs_vthr_t vthr;
    mcs_pkg::mcs_ithr_t ithr;
    logic [N_EL-1:0] subscr;
    logic [N_OC-1:0] oc_assign;
    logic [15:0] kp;
    logic [15:0] ke;
    logic tcs_fault;
    logic tcs_alarm;
    logic cts_alarm;
    logic lop_cond;
    logic lop_alarm;
    logic fuse_fail;
    logic block;
    logic [N_EL-1:0] elem_block;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
  } mcs_state_t;

  mcs_state_t st_reg;
  mcs_state_t st_next;
  logic tcs_fire;
  logic lop_fire;

  // register read decode, unmapped words read as zero
  function automatic logic [31:0] read_reg(input mcs_state_t s, input logic [7:0] a);
    mcs_pkg::mcs_status_t stat;
    stat = '0;
    stat.tcs_fault = s.tcs_fault;
    stat.tcs_alarm = s.tcs_alarm;
    stat.cts_alarm = s.cts_alarm;
    stat.lop_cond = s.lop_cond;
    stat.lop_alarm = s.lop_alarm;
    stat.fuse_fail = s.fuse_fail;
    stat.block = s.block;
    unique case (a)
      mcs_pkg::OFF_CTRL: read_reg = s.ctrl;
      mcs_pkg::OFF_TCS_DLY: read_reg = 32'(s.tcs_dly);
      mcs_pkg::OFF_LOP_DLY: read_reg = 32'(s.lop_dly);
      mcs_pkg::OFF_CTS_LIM: read_reg = s.lim;
      mcs_pkg::OFF_CT_RATING: read_reg = s.rating;
      mcs_pkg::OFF_LOP_VTHR: read_reg = s.vthr;
      mcs_pkg::OFF_LOP_ITHR: read_reg = s.ithr;
      mcs_pkg::OFF_SUBSCR: read_reg = 32'(s.subscr);
      mcs_pkg::OFF_OC_ASSIGN: read_reg = 32'(s.oc_assign);
      mcs_pkg::OFF_STATUS: read_reg = stat;
      default: read_reg = '0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // current transformer arithmetic
  // ---------------------------------------------------------------
  mcs_pkg::mcs_meas_t cm;
  mcs_pkg::mcs_meas_t lm;
  logic signed [39:0] sre, sim, kp40, ke40, cre, cim;
  logic signed [87:0] ere, eim;
  logic [87:0] mag2, lim2, lscale;
  logic cts_over;
  logic [15:0] imax;
  logic [47:0] lim_s;

  // phase sum and earth current scaled to a common base so no divider is needed
  always_comb
  begin
    cm = meas[0];
    imax = cm.i_mag[0];
    sre = '0;
    sim = '0;
    for (int k = 0; k < 3; k++)
    begin
      sre = sre + 40'($signed(cm.i_re[k]));
      sim = sim + 40'($signed(cm.i_im[k]));
      if (cm.i_mag[k] > imax)
        imax = cm.i_mag[k];
    end
    kp40 = $signed(40'(st_reg.kp));
    ke40 = $signed(40'(st_reg.ke));
    cre = sre * kp40 + 40'($signed(cm.ig_re)) * ke40;
    cim = sim * kp40 + 40'($signed(cm.ig_im)) * ke40;
    ere = 88'(cre);
    eim = 88'(cim);
    mag2 = $unsigned(ere * ere + eim * eim);
    // slope term rises in step with the largest current
    lim_s = 48'(st_reg.lim.offset) + ((48'(st_reg.lim.slope) * 48'(imax)) >> mcs_pkg::SLOPE_FRAC);
    lscale = 88'(lim_s) * 88'(st_reg.kp);
    lim2 = lscale * lscale;
    cts_over = mag2 >= lim2;
  end

  // ---------------------------------------------------------------
  // potential loss conditions
  // ---------------------------------------------------------------
  logic any_vlow, all_ilow, res_v_ok, i0_low, no_oc, brk_ok, lop_now;

  always_comb
  begin
    lm = meas[st_reg.ctrl.winding_sel];
    any_vlow = 1'b0;
    all_ilow = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      any_vlow = any_vlow | (lm.v_mag[k] < st_reg.vthr.v_low);
      all_ilow = all_ilow & (lm.i_mag[k] < st_reg.ithr.i_low);
    end
    res_v_ok = (lm.v0 < st_reg.vthr.v0_low)
             | (32'(lm.v2) * mcs_pkg::PCT_FULL > 32'(lm.v1) * mcs_pkg::NEG_SEQ_PCT);
    i0_low = 32'(lm.i0) * mcs_pkg::RES_DIV < 32'(st_reg.ithr.i_rated);
    no_oc = (oc_pickup & st_reg.oc_assign) == '0;
    // breaker ignored when no switchgear is assigned
    brk_ok = !st_reg.ctrl.lop_use_breaker | !st_reg.ctrl.sg_assigned | breaker_closed;
    lop_now = st_reg.ctrl.lop_enable & any_vlow & res_v_ok & all_ilow & i0_low & no_oc & brk_ok;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic tcs_closed, tcs_open, tcs_healthy, tcs_eval;

  always_comb
  begin
    st_next = st_reg;
    // contact and fuse pins pass two flops before anything reads them
    st_next.sync1 = {vt_fuse_fail_input, breaker_open_aux_contact, breaker_closed_aux_contact};
    st_next.sync2 = st_reg.sync1;
    // delay time base, one pulse per delay unit
    st_next.tick = 1'b0;
    st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
    if (st_reg.tick_cnt == 16'(TICK_CYCLES - 1))
    begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end
    // trip circuit: lost supply leaves both inputs low and looks like a break
    tcs_closed = st_reg.sync2[mcs_pkg::SYNC_CLOSED];
    tcs_open = st_reg.sync2[mcs_pkg::SYNC_OPEN];
    tcs_healthy = st_reg.ctrl.two_contact ? (tcs_closed | tcs_open) : tcs_closed;
    tcs_eval = st_reg.ctrl.two_contact | breaker_closed;
    st_next.tcs_fault = st_reg.ctrl.sg_assigned & tcs_eval & !tcs_healthy;
    st_next.tcs_alarm = tcs_fire & st_reg.ctrl.sg_assigned;
    // ratio correction: cross products of the ct ratings
    st_next.kp = 16'(st_reg.rating.phase_prim) * 16'(st_reg.rating.earth_sec);
    st_next.ke = 16'(st_reg.rating.earth_prim) * 16'(st_reg.rating.phase_sec);
    st_next.cts_alarm = st_reg.ctrl.cts_enable & cts_over;
    st_next.lop_cond = lop_now;
    st_next.lop_alarm = lop_fire;
    st_next.fuse_fail = st_reg.ctrl.fuse_assigned & st_reg.sync2[mcs_pkg::SYNC_FUSE];
    st_next.block = st_reg.ctrl.block_allow & (st_reg.lop_alarm | st_reg.fuse_fail);
    st_next.elem_block = {N_EL{st_reg.block}} & st_reg.subscr;
    // ahb data phase write, applied at the closing edge
    if (st_reg.dp_wr)
    begin
      unique case (st_reg.dp_addr)
        mcs_pkg::OFF_CTRL: st_next.ctrl = hwdata;
        mcs_pkg::OFF_TCS_DLY: st_next.tcs_dly = hwdata[15:0];
        mcs_pkg::OFF_LOP_DLY: st_next.lop_dly = hwdata[15:0];
        mcs_pkg::OFF_CTS_LIM: st_next.lim = hwdata;
        mcs_pkg::OFF_CT_RATING: st_next.rating = hwdata;
        mcs_pkg::OFF_LOP_VTHR: st_next.vthr = hwdata;
        mcs_pkg::OFF_LOP_ITHR: st_next.ithr = hwdata;
        mcs_pkg::OFF_SUBSCR: st_next.subscr = hwdata[N_EL-1:0];
        mcs_pkg::OFF_OC_ASSIGN: st_next.oc_assign = hwdata[N_OC-1:0];
        default: ;
      endcase
      st_next.ctrl.rsvd = '0;
    end
    // address phase; reads use the post-write copy so a prior write is seen
    st_next.dp_wr = 1'b0;
    if (hsel && hready && htrans == mcs_pkg::HTRANS_NONSEQ)
    begin
      st_next.dp_wr = hwrite;
      st_next.dp_addr = haddr[mcs_pkg::ADDR_W-1:0];
      if (!hwrite)
        st_next.rdata = read_reg(st_next, haddr[mcs_pkg::ADDR_W-1:0]);
    end
    st_next.ready = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
      st_reg.rating <= mcs_pkg::CT_RATING_RST;
      st_reg.ready <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // persistence timers
  // ---------------------------------------------------------------
  mcs_delay #(.W(16)) u_tcs_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(st_reg.tick),
    .cond(st_reg.tcs_fault),
    .delay(st_reg.tcs_dly),
    .fired(tcs_fire)
  );

  mcs_delay #(.W(16)) u_lop_delay (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(st_reg.tick),
    .cond(st_reg.lop_cond),
    .delay(st_reg.lop_dly),
    .fired(lop_fire)
  );

  // outputs straight from the state flops
  assign hreadyout = st_reg.ready;
  assign hresp = 1'b0 & st_reg.ready;
  assign hrdata = st_reg.rdata;
  assign trip_circuit_alarm = st_reg.tcs_alarm;
  assign cts_alarm = st_reg.cts_alarm;
  assign potential_loss_block_alarm = st_reg.lop_alarm;
  assign fuse_fail = st_reg.fuse_fail;
  assign elem_block = st_reg.elem_block;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tcs_open_idle: assert property (
    !st_reg.ctrl.two_contact && !breaker_closed |=> !st_reg.tcs_fault)
    else $error("trip circuit judged with breaker open in one-contact mode");

  a_tcs_two_watch: assert property (
    st_reg.ctrl.sg_assigned && st_reg.ctrl.two_contact && !breaker_closed
    && st_reg.sync2[1:0] == 2'b00 |=> st_reg.tcs_fault)
    else $error("two-contact break missed with breaker open");

  a_tcs_delayed: assert property (
    $rose(st_reg.tcs_alarm) |-> $past(st_reg.tcs_fault) && $past(st_reg.tcs_fault, 2))
    else $error("trip circuit alarm without held fault");

  a_supply_lost: assert property (
    st_reg.ctrl.sg_assigned && breaker_closed && st_reg.sync2[1:0] == 2'b00 |=> st_reg.tcs_fault)
    else $error("lost trip supply not seen as fault");

  a_tcs_inert: assert property (
    !st_reg.ctrl.sg_assigned |=> !st_reg.tcs_fault ##1 !st_reg.tcs_alarm)
    else $error("trip circuit watch active without switchgear");

  a_cts_limit: assert property (
    st_reg.ctrl.cts_enable |=> st_reg.cts_alarm == $past(cts_over))
    else $error("ct alarm disagrees with limit compare");

  a_lop_oc_inhibit: assert property (
    (oc_pickup & st_reg.oc_assign) != '0 |=> !st_reg.lop_cond ##2 !st_reg.lop_alarm)
    else $error("potential loss seen during overcurrent pickup");

  a_lop_resid: assert property (
    32'(lm.i0) * mcs_pkg::RES_DIV >= 32'(st_reg.ithr.i_rated) |=> !st_reg.lop_cond)
    else $error("potential loss with high residual current");

  a_lop_held: assert property (
    $rose(st_reg.lop_alarm) |-> $past(st_reg.lop_cond) && $past(st_reg.lop_cond, 2))
    else $error("potential loss alarm without held condition");

  a_block_allow: assert property (
    !st_reg.ctrl.block_allow |=> !st_reg.block ##1 st_reg.elem_block == '0)
    else $error("elements blocked with block allow off");

  a_elem_subscr: assert property (
    (st_reg.elem_block & ~$past(st_reg.subscr)) == '0)
    else $error("unsubscribed element blocked");

  a_fuse_input: assert property (
    st_reg.ctrl.fuse_assigned && st_reg.sync2[mcs_pkg::SYNC_FUSE] |=> st_reg.fuse_fail)
    else $error("fuse failure input not reported");

  c_tcs_alarm: cover property ($rose(st_reg.tcs_alarm));
  c_cts_alarm: cover property ($rose(st_reg.cts_alarm));
  c_lop_block: cover property ($rose(st_reg.lop_alarm) ##[1:3] st_reg.elem_block != '0);
  c_fuse_block: cover property ($rose(st_reg.fuse_fail) ##2 st_reg.block);

endmodule // mcs_supervision

/* File: mcs_field_model.sv */
// field side model: trip circuit with breaker aux contacts
`timescale 1ns/1ps
module mcs_field_model (
  input wire logic hclk,
  input wire logic breaker_pos,
  input wire logic supply_on,
  input wire logic wire_ok,
  input wire logic two_contact,
  output logic closed_contact,
  output logic open_contact
);
  // -------------------------------------------------------------
  // contact currents
  // -------------------------------------------------------------
  // current needs supply and an intact loop; unwired open contact reads 0
  always_ff @(posedge hclk)
  begin
    closed_contact <= supply_on & wire_ok & breaker_pos;
    open_contact <= two_contact & supply_on & wire_ok & ~breaker_pos;
  end
endmodule // mcs_field_model

/* File: tb.sv */
// self-checking bench for the supervision block
`timescale 1ns/1ps
module tb;
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  localparam int OFS = 50;
  localparam int SLP = 128;
  logic hclk = 1'h0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  logic breaker_pos, supply_on, wire_ok, two_c, closed_c, open_c, fuse_in;
  logic tca, ctsa, lopa, ff;
  logic [7:0] oc_pickup, elem_block;
  mcs_pkg::mcs_meas_t m0, m1;
  mcs_pkg::mcs_meas_t [1:0] meas;
  integer seed = 32'h85ca;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int pp = 1, ps = 1, ep = 1, es = 1;
  int a, b, g, gi, mg;
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;

  mcs_supervision #(.N_EL(8), .N_OC(8), .TICK_CYCLES(TICK)) mcs_supervision_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .breaker_closed_aux_contact(closed_c), .breaker_open_aux_contact(open_c),
    .vt_fuse_fail_input(fuse_in), .breaker_closed(breaker_pos), .meas(meas),
    .oc_pickup(oc_pickup), .trip_circuit_alarm(tca), .cts_alarm(ctsa),
    .potential_loss_block_alarm(lopa), .fuse_fail(ff), .elem_block(elem_block));

  mcs_field_model mcs_field_model_inst (.hclk(hclk), .breaker_pos(breaker_pos),
    .supply_on(supply_on), .wire_ok(wire_ok), .two_contact(two_c),
    .closed_contact(closed_c), .open_contact(open_c));

  // -------------------------------------------------------------
  // clock, timeout and reporting
  // -------------------------------------------------------------
  initial
  begin
    forever #25 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // -------------------------------------------------------------
  // bus and stimulus tasks
  // -------------------------------------------------------------
  // request held until ready is seen high at an edge
  task automatic ahb(input logic [7:0] ad, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, ad};
    hwrite <= wr;
    htrans <= mcs_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    ahb(ad, 1'h0, 32'h0000_0000);
    check(rd, exp);
    // slave never stalls and always answers okay
    check(32'({hreadyout, hresp}), 32'h0000_0002);
  endtask

  // outputs are looked at mid-cycle, away from the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic apply();
    @(posedge hclk);
    meas[0] <= m0;
    meas[1] <= m1;
  endtask

  function automatic logic cts_exp(input longint sr, input longint gr, input longint gj, input longint im);
    longint re;
    longint ii;
    longint lim;
    re = sr * pp * es + gr * ep * ps;
    ii = gj * ep * ps;
    lim = (OFS + ((SLP * im) >> 8)) * pp * es;
    return (re * re + ii * ii) >= (lim * lim);
  endfunction

  task automatic cts_try(input int x, input int y, input int z, input int gr, input int gj, input int im);
    m0.i_re = {16'(z), 16'(y), 16'(x)};
    m0.ig_re = 16'(gr);
    m0.ig_im = 16'(gj);
    m0.i_mag = {16'(im), 16'(im), 16'(im)};
    apply();
    cyc(4);
    check(ctsa, cts_exp(x + y + z, gr, gj, im));
  endtask

  task automatic lop_chk(input logic ea, input logic [7:0] eb);
    apply();
    cyc(14);
    check(lopa, ea);
    check(elem_block, eb);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    hresetn = 1'h0; hsel = 1'h0; haddr = '0; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2; hwdata = '0;
    breaker_pos = 1'h0; supply_on = 1'h1; wire_ok = 1'h1; two_c = 1'h0; fuse_in = 1'h0;
    oc_pickup = 8'h00; m0 = '0; m1 = '0; meas = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    // register map, unmapped and read-only places
    rchk(mcs_pkg::OFF_CT_RATING, 32'h0011_0011);
    rchk(mcs_pkg::OFF_CTRL, 32'h0000_0000);
    ahb(8'h28, 1'h1, 32'hffff_ffff);
    rchk(8'h28, 32'h0000_0000);
    ahb(mcs_pkg::OFF_STATUS, 1'h1, 32'hffff_ffff);
    rchk(mcs_pkg::OFF_STATUS, 32'h0000_0000);
    ahb(mcs_pkg::OFF_SUBSCR, 1'h1, 32'hffff_ffff);
    rchk(mcs_pkg::OFF_SUBSCR, 32'h0000_00ff);
    ahb(mcs_pkg::OFF_SUBSCR, 1'h1, 32'h0000_0005);
    // trip circuit: 2-tick delay (8 cycles) outlasts contact recognition
    ahb(mcs_pkg::OFF_TCS_DLY, 1'h1, 32'h0000_0002);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0001);
    cyc(20);
    check(tca, 1'h0);
    @(posedge hclk) breaker_pos <= 1'h1;
    cyc(20);
    check(tca, 1'h0);
    @(posedge hclk) wire_ok <= 1'h0;
    cyc(8);
    check(tca, 1'h0);
    cyc(8);
    check(tca, 1'h1);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0000);
    cyc(20);
    check(tca, 1'h0);
    @(posedge hclk);
    breaker_pos <= 1'h0;
    wire_ok <= 1'h1;
    two_c <= 1'h1;
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0003);
    cyc(20);
    check(tca, 1'h0);
    @(posedge hclk) supply_on <= 1'h0;
    cyc(20);
    check(tca, 1'h1);
    rchk(mcs_pkg::OFF_STATUS, 32'h0000_0003);
    @(posedge hclk) supply_on <= 1'h1;
    // ct watch: limit = offset + slope * largest phase current
    ahb(mcs_pkg::OFF_CTS_LIM, 1'h1, {16'(SLP), 16'(OFS)});
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0004);
    cts_try(100, -50, -50, 200, 0, 300);
    cts_try(100, -50, -50, 199, 0, 300);
    for (int k = 0; k < 16; k++)
    begin
      if (k == 8)
      begin
        ahb(mcs_pkg::OFF_CT_RATING, 1'h1, 32'h0011_0021);
        ep = 2;
        cts_try(100, -50, -50, 100, 0, 300);
      end
      a = $random(seed) % 400;
      b = $random(seed) % 400;
      g = $random(seed) % 200;
      gi = $random(seed) % 200;
      mg = $random(seed) & 32'h0000_01ff;
      cts_try(a, b, -(a + b) + (k % 3) * 60, g, gi, mg);
    end
    // potential loss: phase c low, residual low, light load
    ahb(mcs_pkg::OFF_LOP_DLY, 1'h1, 32'h0000_0001);
    ahb(mcs_pkg::OFF_LOP_VTHR, 1'h1, 32'h0064_000a);
    ahb(mcs_pkg::OFF_LOP_ITHR, 1'h1, 32'h0032_0064);
    ahb(mcs_pkg::OFF_OC_ASSIGN, 1'h1, 32'h0000_0001);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0018);
    m0 = '0;
    m0.v_mag = {16'(50), 16'(200), 16'(200)};
    m0.i_mag = {16'(10), 16'(10), 16'(10)};
    m0.v0 = 16'(5);
    m0.v1 = 16'(100);
    m0.i0 = 16'(5);
    m1 = m0;
    m1.v_mag = {16'(200), 16'(200), 16'(200)};
    lop_chk(1'h1, 8'h05);
    @(posedge hclk) oc_pickup <= 8'h02;
    lop_chk(1'h1, 8'h05);
    @(posedge hclk) oc_pickup <= 8'h01;
    lop_chk(1'h0, 8'h00);
    @(posedge hclk) oc_pickup <= 8'h00;
    m0.i0 = 16'(10);
    lop_chk(1'h0, 8'h00);
    m0.i0 = 16'(9);
    m0.v0 = 16'(20);
    m0.v2 = 16'(40);
    lop_chk(1'h0, 8'h00);
    m0.v2 = 16'(41);
    lop_chk(1'h1, 8'h05);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0098);
    lop_chk(1'h0, 8'h00);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0039);
    lop_chk(1'h0, 8'h00);
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0008);
    lop_chk(1'h1, 8'h00);
    // fuse input alone with voltages healthy
    ahb(mcs_pkg::OFF_CTRL, 1'h1, 32'h0000_0058);
    m0.v_mag = {16'(200), 16'(200), 16'(200)};
    @(posedge hclk) fuse_in <= 1'h1;
    lop_chk(1'h0, 8'h05);
    check(ff, 1'h1);
    @(posedge hclk) fuse_in <= 1'h0;
    cyc(8);
    check(ff, 1'h0);
    give_verdict();
  end
endmodule // tb
